//--- include/fbm_pkg.sv
// shared types and constants of the flash boot mode select and map block
// assumes a 32-bit physical address space and an apb slave port with 32-bit data
package fbm_pkg;

    // address space
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // flash array: 16 blocks of 32 KB
    localparam logic [ADDR_W-1:0] FLASH_SIZE = 32'h0008_0000;
    localparam int BLOCK_LSB = 15;
    localparam int BLOCK_MSB = 18;
    localparam int BLOCK_W = BLOCK_MSB - BLOCK_LSB + 1;
    localparam int OFFSET_W = BLOCK_LSB;
    localparam int BANK_BIT = 1;

    // region bases per mode
    localparam logic [ADDR_W-1:0] FLASH_BASE_MAIN = 32'h1fc0_0000;
    localparam logic [ADDR_W-1:0] FLASH_BASE_SHADOW = 32'h4000_0000;
    localparam logic [ADDR_W-1:0] FLASH_BASE_WRITER = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] BOOTROM_FIRST = 32'h1fc0_0000;
    localparam logic [ADDR_W-1:0] BOOTROM_LAST = 32'h1fc0_17ff;
    localparam logic [ADDR_W-1:0] RAM_FIRST = 32'hffff_8000;
    localparam logic [ADDR_W-1:0] RAM_LAST = 32'hffff_cfff;
    localparam logic [ADDR_W-1:0] PERIPH_FIRST = 32'hffff_e000;

    // register offsets (byte addresses)
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_REUSE = 12'h004;
    localparam logic [11:0] REG_PROBE_ADDR = 12'h008;
    localparam logic [11:0] REG_PROBE_RESULT = 12'h00c;

    // status word fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_CAPTURED_BIT = 5;
    localparam int STAT_RUN_BIT = 6;
    localparam int STAT_ROM_BIT = 7;
    localparam int STAT_INTERLEAVE_STRAP_BIT = 8;

    // pin reuse word fields
    localparam int REUSE_BOOT_BIT = 0;
    localparam int REUSE_INTERLEAVE_STRAP_BIT = 1;
    localparam int REUSE_W = 2;
    localparam logic [REUSE_W-1:0] REUSE_RESET = 2'h0;

    // probe result word fields
    localparam int RES_REGION_LSB = 0;
    localparam int RES_BLOCK_LSB = 5;
    localparam int RES_BANK_BIT = 9;
    localparam int RES_OFFSET_LSB = 16;

    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [4:0] {
        MODE_NONE   = 5'h01,
        MODE_INTERLEAVE_STRAP  = 5'h02,
        MODE_ONECLK = 5'h04,
        MODE_SBOOT  = 5'h08,
        MODE_WRITER = 5'h10
    } fbm_mode_type;

    typedef enum logic [4:0] {
        REGION_NONE    = 5'h01,
        REGION_FLASH   = 5'h02,
        REGION_BOOTROM = 5'h04,
        REGION_RAM     = 5'h08,
        REGION_PERIPH  = 5'h10
    } fbm_region_type;

    typedef enum logic [1:0] {
        FETCH_IDLE = 2'h1,
        FETCH_WAIT = 2'h2
    } fbm_fetch_type;

    localparam int STRAP_W = 4;

    typedef struct packed {
        logic width_strap_lo;
        logic width_strap_hi;
        logic boot_strap_n;
        logic interleave_strap;
    } fbm_strap_type;

    typedef struct packed {
        fbm_region_type region;
        logic [BLOCK_W-1:0] block;
        logic [OFFSET_W-1:0] offset;
        logic bank;
    } fbm_decode_type;

endpackage

//--- logic/fbm_strap_sync.sv
// two-flop synchroniser for the strap pins
// assumes pins come straight from the board; stages are not reset so they track during reset
module fbm_strap_sync
    import fbm_pkg::*;
#(
    parameter int WIDTH = STRAP_W
) (
    // clock
    input wire logic pclk,
    // pins
    input wire logic [WIDTH-1:0] raw,
    // synchronised levels
    output logic [WIDTH-1:0] synced
);

    if (WIDTH < 1) begin : g_bad_width
        $error("fbm_strap_sync width must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } fbm_sync_state_type;

    fbm_sync_state_type st;
    fbm_sync_state_type next_st;

    // no reset here: the straps must be seen while reset is still low
    always_comb begin
        next_st.stage1 = raw;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge pclk) begin
        st <= next_st;
    end

    assign synced = st.stage2;

endmodule // fbm_strap_sync

//--- logic/fbm_addr_decode.sv
// address decoder for the flash, boot rom, ram and peripheral regions; writer mode maps flash only, none maps nothing
// assumes a stable mode input; purely combinational
module fbm_addr_decode
    import fbm_pkg::*;
(
    // lookup
    input wire logic [ADDR_W-1:0] addr,
    input wire fbm_mode_type mode,
    // result
    output fbm_decode_type result
);

    logic [ADDR_W-1:0] off_main;
    logic [ADDR_W-1:0] off_shadow;
    logic [ADDR_W-1:0] off_writer;
    logic hit_main;
    logic hit_shadow;
    logic hit_writer;
    logic hit_rom;

    assign off_main = addr - FLASH_BASE_MAIN;
    assign off_shadow = addr - FLASH_BASE_SHADOW;
    assign off_writer = addr - FLASH_BASE_WRITER;
    assign hit_main = off_main < FLASH_SIZE;
    assign hit_shadow = off_shadow < FLASH_SIZE;
    assign hit_writer = off_writer < FLASH_SIZE;
    assign hit_rom = (addr >= BOOTROM_FIRST) && (addr <= BOOTROM_LAST);

    always_comb begin
        result.region = REGION_NONE;
        result.block = '0;
        result.offset = '0;
        result.bank = 1'b0;
        case (mode)
            MODE_INTERLEAVE_STRAP, MODE_ONECLK: begin
                if (hit_main) begin
                    result.region = REGION_FLASH;
                    result.block = off_main[BLOCK_MSB:BLOCK_LSB];
                    result.offset = off_main[OFFSET_W-1:0];
                end else if (hit_shadow) begin
                    result.region = REGION_FLASH;
                    result.block = off_shadow[BLOCK_MSB:BLOCK_LSB];
                    result.offset = off_shadow[OFFSET_W-1:0];
                end
            end
            MODE_SBOOT: begin
                // the rom takes the first 6 KB of the main flash window and the rest of it is unmapped; flash stays reachable at the shadow base
                if (hit_rom) begin
                    result.region = REGION_BOOTROM;
                    result.offset = off_main[OFFSET_W-1:0];
                end else if (hit_shadow) begin
                    result.region = REGION_FLASH;
                    result.block = off_shadow[BLOCK_MSB:BLOCK_LSB];
                    result.offset = off_shadow[OFFSET_W-1:0];
                end
            end
            MODE_WRITER: begin
                if (hit_writer) begin
                    result.region = REGION_FLASH;
                    result.block = off_writer[BLOCK_MSB:BLOCK_LSB];
                    result.offset = off_writer[OFFSET_W-1:0];
                end
            end
            default: begin
                result.region = REGION_NONE;
            end
        endcase
        if (mode == MODE_INTERLEAVE_STRAP || mode == MODE_ONECLK || mode == MODE_SBOOT) begin
            if (addr >= RAM_FIRST && addr <= RAM_LAST) begin
                result.region = REGION_RAM;
            end else if (addr >= PERIPH_FIRST) begin
                result.region = REGION_PERIPH;
            end
        end
        if (mode == MODE_INTERLEAVE_STRAP && result.region == REGION_FLASH) begin
            result.bank = addr[BANK_BIT];
        end
    end

endmodule // fbm_addr_decode

//--- logic/fbm_top.sv
// reset-time mode selection and memory map of the on-chip flash, with an apb status port
// assumes straps come from board pins, presetn is the chip reset, fetch port is on pclk
module fbm_top
    import fbm_pkg::*;
#(
    parameter int APB_ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // strap pins
    input wire fbm_strap_type strap_pins,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,
    // fetch port
    input wire logic acc_valid,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic acc_branch,
    output logic acc_ready,
    output fbm_decode_type acc_result,
    // mode outputs
    output fbm_mode_type mode,
    output logic cpu_run,
    output logic interleave_en,
    output logic boot_from_rom,
    output logic boot_strap_pin_reuse,
    output logic interleave_strap_pin_reuse
);

    if (APB_ADDR_W < 4 || APB_ADDR_W > ADDR_W) begin : g_bad_addr_w
        $error("fbm_top apb address width must be 4 to 32");
    end

    typedef struct packed {
        logic captured;
        fbm_mode_type mode;
        logic cpu_run;
        logic [REUSE_W-1:0] reuse;
        logic [ADDR_W-1:0] probe_addr;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
        fbm_fetch_type fetch;
        logic last_bank;
        logic have_last;
        fbm_decode_type acc_result;
    } fbm_top_state_type;

    localparam fbm_top_state_type ST_RESET = '{
        captured: 1'b0,
        mode: MODE_NONE,
        cpu_run: 1'b0,
        reuse: REUSE_RESET,
        probe_addr: WORD_ZERO,
        prdata: WORD_ZERO,
        pslverr: 1'b0,
        fetch: FETCH_IDLE,
        last_bank: 1'b0,
        have_last: 1'b0,
        acc_result: '{region: REGION_NONE, block: '0, offset: '0, bank: 1'b0}
    };

    fbm_top_state_type st;
    fbm_top_state_type next_st;

    logic [STRAP_W-1:0] sync_vec;
    fbm_strap_type straps;
    fbm_mode_type live_mode;
    fbm_mode_type mode_eff;
    fbm_decode_type acc_dec;
    fbm_decode_type probe_dec;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] result_word;
    logic acc_enable;
    logic slow;

    fbm_strap_sync #(
        .WIDTH(STRAP_W)
    ) u_sync (
        .pclk(pclk),
        .raw(strap_pins),
        .synced(sync_vec)
    );

    assign straps = fbm_strap_type'(sync_vec);

    always_comb begin
        if (straps.width_strap_lo && straps.width_strap_hi) begin
            if (!straps.boot_strap_n) begin
                live_mode = MODE_SBOOT;
            end else if (straps.interleave_strap) begin
                live_mode = MODE_INTERLEAVE_STRAP;
            end else begin
                live_mode = MODE_ONECLK;
            end
        end else if (!straps.width_strap_lo && straps.width_strap_hi) begin
            live_mode = MODE_WRITER;
        end else begin
            live_mode = MODE_NONE;
        end
    end

    // writer mode lives while reset is held, so the map follows the straps until capture
    assign mode_eff = st.captured ? st.mode : live_mode;

    fbm_addr_decode u_acc_dec (
        .addr(acc_addr),
        .mode(mode_eff),
        .result(acc_dec)
    );

    fbm_addr_decode u_probe_dec (
        .addr(st.probe_addr),
        .mode(mode_eff),
        .result(probe_dec)
    );

    always_comb begin
        status_word = WORD_ZERO;
        status_word[STAT_MODE_LSB +: 5] = st.mode;
        status_word[STAT_CAPTURED_BIT] = st.captured;
        status_word[STAT_RUN_BIT] = st.cpu_run;
        status_word[STAT_ROM_BIT] = boot_from_rom;
        status_word[STAT_INTERLEAVE_STRAP_BIT] = interleave_en;
        result_word = WORD_ZERO;
        result_word[RES_REGION_LSB +: 5] = probe_dec.region;
        result_word[RES_BLOCK_LSB +: BLOCK_W] = probe_dec.block;
        result_word[RES_BANK_BIT] = probe_dec.bank;
        result_word[RES_OFFSET_LSB +: OFFSET_W] = probe_dec.offset;
    end

    assign acc_enable = st.captured && (st.mode != MODE_NONE);
    // same bank again, a branch or no history costs the second clock
    assign slow = (st.mode == MODE_INTERLEAVE_STRAP) && (acc_dec.region == REGION_FLASH)
        && (acc_branch || !st.have_last || (acc_dec.bank == st.last_bank));
    assign acc_ready = acc_valid && acc_enable && ((st.fetch == FETCH_WAIT) || !slow);

    always_comb begin
        next_st = st;
        next_st.captured = 1'b1;
        if (!st.captured) begin
            next_st.mode = live_mode;
        end
        // writer mode keeps the processor stopped
        next_st.cpu_run = st.captured && (st.mode != MODE_WRITER) && (st.mode != MODE_NONE);

        // apb: read data and error are prepared in the setup cycle
        if (psel && !penable) begin
            next_st.prdata = WORD_ZERO;
            next_st.pslverr = 1'b0;
            if (paddr == APB_ADDR_W'(REG_STATUS)) begin
                next_st.prdata = status_word;
                next_st.pslverr = pwrite;
            end else if (paddr == APB_ADDR_W'(REG_REUSE)) begin
                next_st.prdata[REUSE_W-1:0] = st.reuse;
            end else if (paddr == APB_ADDR_W'(REG_PROBE_ADDR)) begin
                next_st.prdata = st.probe_addr;
            end else if (paddr == APB_ADDR_W'(REG_PROBE_RESULT)) begin
                next_st.prdata = result_word;
                next_st.pslverr = pwrite;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        // writes land only at the access edge
        if (psel && penable && pwrite) begin
            if (paddr == APB_ADDR_W'(REG_REUSE)) begin
                next_st.reuse = pwdata[REUSE_W-1:0] & {REUSE_W{st.captured}};
            end else if (paddr == APB_ADDR_W'(REG_PROBE_ADDR)) begin
                next_st.probe_addr = pwdata;
            end
        end

        case (st.fetch)
            FETCH_IDLE: begin
                if (acc_valid && acc_enable && slow) begin
                    next_st.fetch = FETCH_WAIT;
                end
            end
            FETCH_WAIT: begin
                if (acc_ready) begin
                    next_st.fetch = FETCH_IDLE;
                end
            end
            default: begin
                next_st.fetch = FETCH_IDLE;
            end
        endcase
        if (acc_ready) begin
            next_st.acc_result = acc_dec;
            if (acc_dec.region == REGION_FLASH) begin
                next_st.last_bank = acc_dec.bank;
                next_st.have_last = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pready = psel && penable;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign acc_result = st.acc_result;
    assign mode = mode_eff;
    assign cpu_run = st.cpu_run;
    // interleave choice from the captured mode
    assign interleave_en = st.captured && (st.mode == MODE_INTERLEAVE_STRAP);
    assign boot_from_rom = st.captured && (st.mode == MODE_SBOOT);
    assign boot_strap_pin_reuse = st.reuse[REUSE_BOOT_BIT];
    assign interleave_strap_pin_reuse = st.reuse[REUSE_INTERLEAVE_STRAP_BIT];

    sequence s_release;
        !st.captured ##1 st.captured;
    endsequence

    sequence s_slow_access;
        acc_valid && !acc_ready ##1 acc_valid && acc_ready;
    endsequence

    a_mode_from_straps: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_release |-> st.mode == $past(live_mode))
        else $error("captured mode differs from strap decode at release");

    a_mode_held: assert property (
        @(posedge pclk) disable iff (!presetn)
        st.captured |=> $stable(st.mode) && st.captured)
        else $error("mode changed after capture");

    a_run_after_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_release ##0 (st.mode != MODE_WRITER && st.mode != MODE_NONE) |=> cpu_run)
        else $error("processor not running one cycle after capture");

    a_writer_no_run: assert property (
        @(posedge pclk) disable iff (!presetn)
        st.mode == MODE_WRITER |-> !cpu_run)
        else $error("processor runs in writer mode");

    a_interleave_strap_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_release |-> interleave_en == ($past(live_mode) == MODE_INTERLEAVE_STRAP))
        else $error("interleave enable does not follow the strap");

    a_bootrom_vector: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_ready && boot_from_rom && acc_addr >= BOOTROM_FIRST && acc_addr <= BOOTROM_LAST
        |=> acc_result.region == REGION_BOOTROM)
        else $error("boot vector not served by the boot rom");

    a_shadow_alias: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_ready && (st.mode == MODE_INTERLEAVE_STRAP || st.mode == MODE_ONECLK)
        && (acc_addr - FLASH_BASE_SHADOW) < FLASH_SIZE
        |=> acc_result.region == REGION_FLASH
        && acc_result.block == $past(acc_addr[BLOCK_MSB:BLOCK_LSB]))
        else $error("shadow address not mapped to the same flash block");

    // block numbering from the vector base
    a_block_number: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_ready && (st.mode == MODE_INTERLEAVE_STRAP || st.mode == MODE_ONECLK)
        && (acc_addr - FLASH_BASE_MAIN) < FLASH_SIZE
        |=> acc_result.region == REGION_FLASH
        && acc_result.block == $past(acc_addr[BLOCK_MSB:BLOCK_LSB]))
        else $error("flash block index wrong");

    a_writer_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        st.captured && st.mode == MODE_WRITER
        |-> (probe_dec.region == REGION_FLASH) == (st.probe_addr < FLASH_SIZE))
        else $error("writer mode map wrong");

    a_ram_window: assert property (
        @(posedge pclk) disable iff (!presetn)
        st.captured && st.mode != MODE_WRITER && st.mode != MODE_NONE
        && st.probe_addr >= RAM_FIRST && st.probe_addr <= RAM_LAST
        |-> probe_dec.region == REGION_RAM)
        else $error("ram window not decoded");

    a_branch_two_clk: assert property (
        @(posedge pclk) disable iff (!presetn)
        st.fetch == FETCH_IDLE && acc_valid && acc_branch && acc_enable
        && st.mode == MODE_INTERLEAVE_STRAP && acc_dec.region == REGION_FLASH
        |-> s_slow_access)
        else $error("interleaved branch fetch did not take two clocks");

    a_reuse_after_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        (boot_strap_pin_reuse || interleave_strap_pin_reuse) |-> st.captured)
        else $error("strap pin reused before release");

endmodule // fbm_top

//--- sim/fbm_board.sv
// board side of the block: strap pins and the reset source
// assumes the bench asks for a new boot with start, and hold keeps reset low
module fbm_board
    import fbm_pkg::*;
(
    // clock
    input wire logic pclk,
    // bench requests
    input wire logic start,
    input wire logic hold,
    input wire fbm_strap_type want,
    // to the device
    output logic presetn,
    output fbm_strap_type strap_pins,
    output logic [2:0] writer_cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 4;
    initial begin
        presetn = 1'b0;
        strap_pins = '0;
        writer_cfg = 3'h1;
    end
    always @(posedge pclk) begin
        if (start) begin
            presetn <= 1'b0;
            strap_pins <= want;
            cnt <= 12;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (!hold) begin
            presetn <= 1'b1;
        end
    end
endmodule // fbm_board

//--- sim/tb.sv
// boots the block in each strap mode except none, then checks status, pin reuse and the map
// assumes fbm_board drives reset and straps; apb and fetch port are driven here
module tb
    import fbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [32:0] v;
        logic [32:0] m;
    } fbm_note_type;
    logic pclk = 1'b0;
    logic hs = 1'b0;
    logic presetn, start, hold, psel, penable, pwrite, pready, pslverr, acc_valid, acc_branch;
    logic acc_ready, cpu_run, interleave_en, boot_from_rom, boot_reuse, interleave_strap_reuse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, acc_addr;
    fbm_strap_type want, strap_pins;
    fbm_decode_type acc_result;
    fbm_mode_type mode;
    fbm_note_type rq[$], fq[$];
    int seed = 81976;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    always #25 pclk = ~pclk;
    fbm_board fbm_board_i (.pclk(pclk), .start(start), .hold(hold), .want(want),
        .presetn(presetn), .strap_pins(strap_pins), .writer_cfg());
    fbm_top fbm_top_i (.pclk(pclk), .presetn(presetn), .strap_pins(strap_pins),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_branch(acc_branch), .acc_ready(acc_ready),
        .acc_result(acc_result), .mode(mode), .cpu_run(cpu_run),
        .interleave_en(interleave_en), .boot_from_rom(boot_from_rom),
        .boot_strap_pin_reuse(boot_reuse), .interleave_strap_pin_reuse(interleave_strap_reuse));
    task automatic wrap_up;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // results are compared one edge after they appear, against the oldest note
    always @(posedge pclk) begin
        fbm_note_type n;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            n = rq.pop_front();
            chk({pslverr, prdata} & n.m, n.v & n.m);
        end
        if (hs) begin
            n = fq.pop_front();
            chk(33'(acc_result) & n.m, n.v & n.m);
        end
        hs <= acc_valid === 1'b1 && acc_ready === 1'b1;
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    // an idle edge closes each transfer so psel is never set twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [32:0] v, input logic [32:0] m);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        rq.push_back({v, m});
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fetch(input logic [31:0] a, input logic [32:0] v);
        int n;
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_branch <= 1'($random(seed));
        fq.push_back({v, {33{1'b1}}});
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (acc_ready !== 1'b1 && n < 20);
        chk(33'(acc_ready), 33'(1));
    endtask
    task automatic run(input fbm_strap_type s, input fbm_mode_type md, input logic [31:0] b0,
            input logic [31:0] b1, input logic [2:0] f, input logic [19:0] rg);
        logic [31:0] pa [4];
        logic [14:0] off;
        logic [32:0] st;
        pa = '{RAM_FIRST, RAM_LAST + 32'h1, PERIPH_FIRST, BOOTROM_FIRST};
        st = 33'(md) | 33'(1) << STAT_CAPTURED_BIT | 33'(f[0]) << STAT_RUN_BIT;
        st = st | 33'(f[1]) << STAT_ROM_BIT | 33'(f[2]) << STAT_INTERLEAVE_STRAP_BIT;
        want <= s;
        start <= 1'b1;
        hold <= md == MODE_WRITER;
        @(posedge pclk);
        start <= 1'b0;
        repeat (18) @(posedge pclk);
        if (md == MODE_WRITER) begin
            chk(33'(mode), 33'(MODE_WRITER));
            chk(33'(cpu_run), 33'(0));
            hold <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        chk(33'(mode), 33'(md));
        chk(33'({interleave_en, boot_from_rom, cpu_run}), 33'(f));
        apb(1'b1, REG_STATUS, 32'h1f, {1'b1, WORD_ZERO}, {1'b1, WORD_ZERO});
        apb(1'b0, REG_STATUS, '0, st, {33{1'b1}});
        apb(1'b0, REG_REUSE, '0, 33'(REUSE_RESET), {33{1'b1}});
        apb(1'b1, REG_REUSE, 32'h3, '0, {1'b1, WORD_ZERO});
        apb(1'b0, REG_REUSE, '0, 33'h3, {33{1'b1}});
        chk(33'({interleave_strap_reuse, boot_reuse}), 33'h3);
        apb(1'b0, 12'h010, '0, {1'b1, WORD_ZERO}, {33{1'b1}});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, REG_PROBE_ADDR, pa[i], '0, {1'b1, WORD_ZERO});
            apb(1'b0, REG_PROBE_RESULT, '0, 33'(rg[5*i +: 5]), 33'h1f);
        end
        // every block at b0 then b1 (both aliases only in the interleave and one-clock runs), random offsets so the bank bit moves
        for (int j = 0; j < 2; j++) begin
            for (int n = 0; n < 16; n++) begin
                off = 15'($random(seed));
                fetch((j ? b1 : b0) + 32'(n) * 32'h8000 + 32'(off),
                    33'({REGION_FLASH, 4'(n), off, off[BANK_BIT] & f[2]}));
            end
        end
        if (md == MODE_SBOOT)
            fetch(BOOTROM_LAST,
                33'({REGION_BOOTROM, 4'h0, 15'(BOOTROM_LAST - BOOTROM_FIRST), 1'b0}));
        acc_valid <= 1'b0;
        @(posedge pclk);
        $display("test mode %h done", md);
    endtask
    initial begin
        {start, hold, psel, penable, pwrite, acc_valid, acc_branch} = '0;
        {paddr, pwdata, acc_addr, want} = '0;
        repeat (6) @(posedge pclk);
        run('{1'b1, 1'b1, 1'b1, 1'b1}, MODE_INTERLEAVE_STRAP, FLASH_BASE_MAIN, FLASH_BASE_SHADOW, 3'h5,
            {REGION_FLASH, REGION_PERIPH, REGION_NONE, REGION_RAM});
        run('{1'b1, 1'b1, 1'b1, 1'b0}, MODE_ONECLK, FLASH_BASE_MAIN, FLASH_BASE_SHADOW, 3'h1,
            {REGION_FLASH, REGION_PERIPH, REGION_NONE, REGION_RAM});
        run('{1'b1, 1'b1, 1'b0, 1'b0}, MODE_SBOOT, FLASH_BASE_SHADOW, FLASH_BASE_SHADOW, 3'h3,
            {REGION_BOOTROM, REGION_PERIPH, REGION_NONE, REGION_RAM});
        run('{1'b0, 1'b1, 1'b0, 1'b0}, MODE_WRITER, FLASH_BASE_WRITER, FLASH_BASE_WRITER,
            3'h0, {4{REGION_NONE}});
        wrap_up();
    end
endmodule // tb
